/* pkg/pscr_pkg.sv */
// shared constants and types for the paged diode and calibration window
package pscr_pkg;
    localparam logic [7:0] APP_MAIN           = 8'h03;
    localparam logic [7:0] PAGE_DIODE_FIRST   = 8'h17;
    localparam logic [7:0] PAGE_DIODE_SECOND  = 8'h18;
    localparam logic [7:0] PAGE_CALIBRATION   = 8'h19;

    localparam logic [7:0] DIODE_ENABLE_MASK_START   = 8'h24;
    localparam logic [7:0] DIODE_ENABLE_MASK_END     = 8'h41;
    localparam logic [7:0] CHANNEL_SELECT_MASK_START = 8'h42;
    localparam logic [7:0] CHANNEL_SELECT_MASK_END   = 8'h8c;
    localparam logic [7:0] MASK_HORIZONTAL_SHIFT     = 8'h8d;
    localparam logic [7:0] MASK_VERTICAL_SHIFT       = 8'h8e;
    localparam logic [7:0] MASK_HORIZONTAL_EXTENT    = 8'h8f;
    localparam logic [7:0] MASK_VERTICAL_EXTENT      = 8'h90;
    localparam logic [7:0] CALIBRATION_BLOCK_START   = 8'h24;
    localparam logic [7:0] CALIBRATION_RESULT_COPY   = 8'hdc;
    localparam logic [7:0] CALIBRATION_BLOCK_END     = 8'hdf;

    localparam int DIODE_BYTES = 109;
    localparam int CAL_BYTES   = 188;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE  = 8'h00;

    // one register access from the serial slave front end
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pscr_access_t;

    // page decode result
    typedef struct packed {
        logic diode_first;
        logic diode_second;
        logic calibration;
        logic diode_range;
        logic cal_range;
    } pscr_hit_t;

    // mask placement handed to the measurement engine
    typedef struct packed {
        logic [7:0] x_shift;
        logic [7:0] y_shift;
        logic [7:0] x_extent;
        logic [7:0] y_extent;
    } pscr_geom_t;
endpackage : pscr_pkg

/* rtl/pscr_page_decode.sv */
// page and offset decode for the paged window
`timescale 1ns/1ns
module pscr_page_decode
    import pscr_pkg::*;
(
    input  wire logic [7:0] app_id,
    input  wire logic [7:0] page_sel,
    input  wire logic       mux_variant,
    input  wire logic [7:0] addr,
    output pscr_hit_t       hit
);
    wire app_ok = (app_id == APP_MAIN);

    assign hit.diode_first  = app_ok && (page_sel == PAGE_DIODE_FIRST);
    // second page only exists on the multiplexing variant
    assign hit.diode_second = app_ok && mux_variant
                              && (page_sel == PAGE_DIODE_SECOND);
    assign hit.calibration  = app_ok && (page_sel == PAGE_CALIBRATION);
    assign hit.diode_range  = (addr >= DIODE_ENABLE_MASK_START)
                              && (addr <= MASK_VERTICAL_EXTENT);
    assign hit.cal_range    = (addr >= CALIBRATION_BLOCK_START)
                              && (addr <= CALIBRATION_BLOCK_END);
endmodule : pscr_page_decode

/* rtl/pscr_regs.sv */
// paged diode configuration and factory calibration register window
// What this block does
// - pages open only with app 0x03; 0x17/0x18 diode, 0x19 calibration
// - page 0x17 holds 3x3 or first multiplexed 4x4 measurement mask
// - page 0x18 exists only on multiplexing variant, second measurement
// - highest-zone mode refuses diode page writes and posts a warning
// - enable mask bytes 0x24 to 0x41, read/write, reset zero
// - channel select bytes 0x42 to 0x8c, read/write, reset zero
// - x/y shifts at 0x8d/0x8e are signed, twice the diode offset
// - calibration page bytes 0x24 to 0xdf, read/write, reset zero
// - byte 0xdc copies calibration status; zero means success
`timescale 1ns/1ns
module pscr_regs
    import pscr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [7:0]   app_id,
    input  wire logic [7:0]   page_sel,
    input  wire logic         mux_variant,
    input  wire logic         max_zone_mode,
    input  pscr_access_t      acc,
    output logic [7:0]        rdata,
    output logic              rvalid,
    input  wire logic [7:0]   cal_status,
    input  wire logic         cal_capture,
    output logic              store_warning,
    output pscr_geom_t        geom_first,
    output pscr_geom_t        geom_second,
    output logic [7:0]        cal_result
);
    logic       rst_meta;
    logic       rst_n_q;
    logic [7:0] diode_mem [2][DIODE_BYTES];
    logic [7:0] cal_mem [CAL_BYTES];
    pscr_hit_t  hit;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n_q  <= rst_meta;
        end
    end

    function automatic logic [6:0] diode_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - DIODE_ENABLE_MASK_START;
        return d[6:0];
    endfunction : diode_idx

    function automatic logic [7:0] cal_idx(input logic [7:0] a);
        return a - CALIBRATION_BLOCK_START;
    endfunction : cal_idx

    pscr_page_decode u_decode (
        .app_id      (app_id),
        .page_sel    (page_sel),
        .mux_variant (mux_variant),
        .addr        (acc.addr),
        .hit         (hit)
    );

    wire        diode_page = hit.diode_first || hit.diode_second;
    wire        page_bank  = hit.diode_second;
    wire [6:0]  d_idx      = diode_idx(acc.addr);
    wire [7:0]  c_idx      = cal_idx(acc.addr);
    wire        diode_acc  = diode_page && hit.diode_range;
    wire        cal_acc    = hit.calibration && hit.cal_range;
    // refused store in highest-zone mode: storage stays as it was
    wire        diode_wr   = acc.wr && diode_acc
                             && !max_zone_mode;
    wire        refused_wr = acc.wr && diode_acc && max_zone_mode;
    wire        cal_wr     = acc.wr && cal_acc;
    wire [7:0]  copy_idx   = cal_idx(CALIBRATION_RESULT_COPY);
    wire [7:0]  next_rdata = diode_acc ? diode_mem[page_bank][d_idx]
                           : cal_acc   ? cal_mem[c_idx]
                           : READ_IDLE;

    // diode pages: 0x17 first / non-multiplexed, 0x18 second slot
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int p = 0; p < 2; p++) begin
                for (int i = 0; i < DIODE_BYTES; i++) begin
                    diode_mem[p][i] <= BYTE_RESET;
                end
            end
        end else if (diode_wr) begin
            diode_mem[page_bank][d_idx] <= acc.wdata;
        end
    end

    // capture beats a host write to the copy byte in the same cycle
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < CAL_BYTES; i++) begin
                cal_mem[i] <= BYTE_RESET;
            end
        end else begin
            if (cal_wr) begin
                cal_mem[c_idx] <= acc.wdata;
            end
            if (cal_capture) begin
                cal_mem[copy_idx] <= cal_status;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata         <= READ_IDLE;
            rvalid        <= 1'b0;
            store_warning <= 1'b0;
        end else begin
            rvalid        <= acc.rd;
            store_warning <= refused_wr;
            if (acc.rd) begin
                rdata <= next_rdata;
            end
        end
    end

    // shifts pass through untouched: signed, half-diode units
    function automatic pscr_geom_t geom_of(input logic b);
        pscr_geom_t g;
        g.x_shift  = diode_mem[b][diode_idx(MASK_HORIZONTAL_SHIFT)];
        g.y_shift  = diode_mem[b][diode_idx(MASK_VERTICAL_SHIFT)];
        g.x_extent = diode_mem[b][diode_idx(MASK_HORIZONTAL_EXTENT)];
        g.y_extent = diode_mem[b][diode_idx(MASK_VERTICAL_EXTENT)];
        return g;
    endfunction : geom_of

    // always_comb, not assign: the function reads storage outside its args
    always_comb begin
        geom_first  = geom_of(1'b0);
        geom_second = geom_of(1'b1);
    end
    assign cal_result  = cal_mem[copy_idx];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    refused_warn_a: assert property (
        refused_wr |=> store_warning
    ) else $error("refused store did not post a warning");

    refused_keep_a: assert property (
        refused_wr && hit.diode_first && acc.addr == MASK_HORIZONTAL_SHIFT
        |=> $stable(geom_first.x_shift)
    ) else $error("refused store changed the mask");

    first_store_a: assert property (
        acc.wr && hit.diode_first && !max_zone_mode
        && acc.addr == MASK_HORIZONTAL_SHIFT
        |=> geom_first.x_shift == $past(acc.wdata)
    ) else $error("first page shift not stored");

    second_absent_a: assert property (
        acc.rd && !mux_variant && page_sel == PAGE_DIODE_SECOND
        |=> rdata == READ_IDLE
    ) else $error("second page visible without variant");

    wrong_app_a: assert property (
        acc.rd && app_id != APP_MAIN |=> rdata == READ_IDLE && rvalid
    ) else $error("window readable outside main app");

    cal_copy_a: assert property (
        cal_capture |=> cal_result == $past(cal_status)
    ) else $error("calibration status not copied");

    cal_end_a: assert property (
        acc.rd && hit.calibration && acc.addr > CALIBRATION_BLOCK_END
        |=> rdata == READ_IDLE
    ) else $error("read beyond calibration block");

    read_lat_a: assert property (
        acc.rd |=> rvalid ##1 (!rvalid || $past(acc.rd))
    ) else $error("read answer timing wrong");

    no_page_keep_a: assert property (
        acc.wr && app_id != APP_MAIN |=> $stable(geom_first)
        && $stable(geom_second) && !store_warning
    ) else $error("write outside valid page changed storage");
endmodule : pscr_regs

/* tb/pscr_host.sv */
// host model issuing single byte register accesses
`timescale 1ns/1ns
module pscr_host
    import pscr_pkg::*;
(
    input  wire logic    clk,
    output pscr_access_t acc
);
    initial acc = '0;
    // released bus shows inverted address and data, never a stale match
    task automatic put(input logic [7:0] a, input logic [7:0] d,
                       input logic w);
        @(negedge clk);
        acc <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(negedge clk);
        acc <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : put
endmodule : pscr_host

/* tb/test_paged_spad_and_calibration_regs.sv */
// self-checking bench for the paged diode and calibration window
`timescale 1ns/1ns
module test_paged_spad_and_calibration_regs;
    import pscr_pkg::*;
    logic         clk = 0, reset_n = 0, mux_variant = 0;
    logic         max_zone_mode = 0, cal_capture = 0;
    logic [7:0]   app_id = APP_MAIN, page_sel = PAGE_DIODE_FIRST;
    logic [7:0]   cal_status = 8'h00, rdata, cal_result;
    logic         rvalid, store_warning;
    pscr_access_t acc;
    pscr_geom_t   geom_first, geom_second;
    int           err_total = 0, tests_run = 0, cycles = 0;
    logic [7:0]   exp_q[$], vals[4];
    logic [7:0]   edges[4] = '{8'h24, 8'h41, 8'h42, 8'h8c};
    logic [15:0]  lfsr = 16'h520b; // seed 21003

    always #25 clk = ~clk;
    pscr_host host (.clk(clk), .acc(acc));
    pscr_regs dut (.clk(clk), .reset_n(reset_n), .app_id(app_id),
        .page_sel(page_sel), .mux_variant(mux_variant),
        .max_zone_mode(max_zone_mode), .acc(acc), .rdata(rdata),
        .rvalid(rvalid), .cal_status(cal_status),
        .cal_capture(cal_capture), .store_warning(store_warning),
        .geom_first(geom_first), .geom_second(geom_second),
        .cal_result(cal_result));

    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic check_read(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_read
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.put(a, 8'h00, 1'b0);
    endtask : rd
    task automatic note(input string s);
        $display("test %0s finished", s);
    endtask : note
    task automatic wrap_up;
        // a read that never answered is a mismatch too
        err_total += exp_q.size();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // read results land one cycle after the strobe edge
    always @(negedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            wrap_up();
        end
        if (rvalid === 1'b1) begin
            if (exp_q.size() > 0) begin
                check_read(rdata, exp_q.pop_front());
            end else begin
                err_total++;
                $display("Error at %0t: got %h expected no read", $time,
                         rdata);
            end
        end
    end

    initial begin
        repeat (10) @(negedge clk);
        reset_n = 1;
        repeat (3) @(negedge clk);
        rd(DIODE_ENABLE_MASK_START, BYTE_RESET);
        rd(CHANNEL_SELECT_MASK_END, BYTE_RESET);
        page_sel = PAGE_CALIBRATION;
        rd(CALIBRATION_BLOCK_END, BYTE_RESET);
        note("reset");
        page_sel = PAGE_DIODE_FIRST;
        foreach (edges[i]) begin
            lfsr = step(lfsr);
            vals[i] = lfsr[7:0];
            host.put(edges[i], vals[i], 1'b1);
            rd(edges[i], vals[i]);
        end
        host.put(8'h91, 8'h5a, 1'b1);
        rd(8'h91, READ_IDLE);
        note("masks");
        host.put(MASK_HORIZONTAL_SHIFT, 8'hfb, 1'b1);
        check(geom_first.x_shift, 8'hfb);
        host.put(MASK_VERTICAL_SHIFT, 8'h06, 1'b1);
        check(geom_first.y_shift, 8'h06);
        host.put(MASK_HORIZONTAL_EXTENT, 8'h12, 1'b1);
        host.put(MASK_VERTICAL_EXTENT, 8'h0a, 1'b1);
        check(geom_first.x_extent, 8'h12);
        check(geom_first.y_extent, 8'h0a);
        note("geometry");
        mux_variant = 1;
        page_sel = PAGE_DIODE_SECOND;
        host.put(MASK_HORIZONTAL_SHIFT, 8'h04, 1'b1);
        check(geom_second.x_shift, 8'h04);
        check(geom_first.x_shift, 8'hfb);
        mux_variant = 0;
        host.put(MASK_HORIZONTAL_SHIFT, 8'h22, 1'b1);
        rd(MASK_HORIZONTAL_SHIFT, READ_IDLE);
        mux_variant = 1;
        rd(MASK_HORIZONTAL_SHIFT, 8'h04);
        note("second page");
        app_id = 8'h00;
        page_sel = PAGE_DIODE_FIRST;
        host.put(MASK_HORIZONTAL_SHIFT, 8'h33, 1'b1);
        rd(MASK_HORIZONTAL_SHIFT, READ_IDLE);
        app_id = APP_MAIN;
        rd(MASK_HORIZONTAL_SHIFT, 8'hfb);
        max_zone_mode = 1;
        host.put(DIODE_ENABLE_MASK_START, 8'h77, 1'b1);
        check({7'h00, store_warning}, 8'h01);
        host.put(MASK_HORIZONTAL_SHIFT, 8'h55, 1'b1);
        check(geom_first.x_shift, 8'hfb);
        max_zone_mode = 0;
        rd(DIODE_ENABLE_MASK_START, vals[0]);
        note("refusals");
        page_sel = PAGE_CALIBRATION;
        cal_status = 8'h05;
        cal_capture = 1;
        @(negedge clk);
        cal_capture = 0;
        check(cal_result, 8'h05);
        rd(CALIBRATION_RESULT_COPY, 8'h05);
        host.put(CALIBRATION_BLOCK_END, 8'hc3, 1'b1);
        rd(CALIBRATION_BLOCK_END, 8'hc3);
        rd(CALIBRATION_BLOCK_START, BYTE_RESET);
        rd(CALIBRATION_BLOCK_END + 8'h01, READ_IDLE);
        note("calibration");
        repeat (4) @(negedge clk);
        wrap_up();
    end
endmodule : test_paged_spad_and_calibration_regs
